//--- cueh_pkg.sv
// package for the control unit error handler: offsets, fields, reset values
// assumes a 32-bit apb master and one clock domain
package cueh_pkg;

  // ==========================================================
  // external register numbers seen by the program
  localparam logic [7:0] XR_FORCE_CHECK = 8'h78;
  localparam logic [7:0] XR_BYPASS_CTL  = 8'h79;
  localparam logic [7:0] XR_SET_MASK    = 8'h7e;
  localparam logic [7:0] XR_RESET_MASK  = 8'h7f;
  localparam logic [3:0] XR_7X_GROUP    = 4'h7;

  // ==========================================================
  // bit positions inside byte 1 of an output halfword
  localparam int BYP_SET_BIT  = 4;
  localparam int BYP_CLR_BIT  = 5;
  localparam int L1_MASK_BIT  = 1;
  localparam int BYTE1_LSB    = 0;

  // ==========================================================
  // control word field marking a maintenance adapter operation
  localparam int MAINT_AIO_BIT = 0;

  // ==========================================================
  // apb register byte addresses
  localparam logic [11:0] ADDR_MAINT_CTL  = 12'h000;
  localparam logic [11:0] ADDR_STATUS     = 12'h004;
  localparam logic [11:0] ADDR_HARD_LATCH = 12'h008;
  localparam logic [11:0] ADDR_PROG_ERR   = 12'h00c;

  // maintenance control fields
  localparam int MC_BYPASS   = 0;
  localparam int MC_BUS_STOP = 1;
  localparam int MC_CLEAR    = 2;
  localparam int MC_FORCED   = 3;

  // hard latch field positions
  localparam int HL_LS_PAR   = 0;
  localparam int HL_Z_PAR    = 1;
  localparam int HL_AB_PAR   = 2;
  localparam int HL_ALU_CMP  = 3;
  localparam int HL_IOD_PAR  = 4;
  localparam int HL_PRE_PAR  = 5;
  localparam int HL_SAR_PAR  = 6;
  localparam int HL_L1_PROG  = 7;
  localparam int HL_BUS_STOP = 8;
  localparam int HL_CTL_PAR  = 9;
  localparam int HL_WIDTH    = 10;

  // program error fields
  localparam int PE_LVL5_IO  = 0;
  localparam int PE_INV_OP   = 1;
  localparam int PE_ADP_PGM  = 2;
  localparam int PE_WIDTH    = 3;

  localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
  localparam logic [6:0]  VALID_OPS   = 7'd53;

  typedef enum logic [1:0] {
    CUEH_RUN     = 2'b00,
    CUEH_STOPPED = 2'b01
  } cueh_state_t;

endpackage

//--- cueh_error_handler.sv
// control unit error handler: detection, classification and reaction
// assumes a 32-bit apb master, one clock; checker inputs are same-domain strobes
`timescale 1ns/1ps
module cueh_error_handler
  import cueh_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // program instruction stream
  input  wire logic              instr_valid,
  input  wire logic              instr_is_io,
  input  wire logic              instr_is_output,
  input  wire logic [7:0]        instr_ext_reg,
  input  wire logic [15:0]       instr_data,
  input  wire logic              instr_opcode_valid,
  input  wire logic              ext_reg_valid,
  input  wire logic [2:0]        prog_level,
  // checkers
  input  wire logic              ls_read,
  input  wire logic [2:0]        ls_byte_par_err,
  input  wire logic [2:0]        z_byte_par_err,
  input  wire logic              alu_op,
  input  wire logic              a_bus_par_err,
  input  wire logic              b_bus_par_err,
  input  wire logic              a_bus_degate,
  input  wire logic              b_bus_degate,
  input  wire logic [7:0]        alu_result_a,
  input  wire logic [7:0]        alu_result_b,
  input  wire logic              alu_par_in,
  input  wire logic              io_dreg_load,
  input  wire logic              io_dreg_from_bus,
  input  wire logic              io_dreg_par_err,
  input  wire logic              prefetch_xfer,
  input  wire logic              prefetch_par_err,
  input  wire logic              storage_addr_reg_par_err,
  input  wire logic              control_store_par_err,
  // adapter side
  input  wire logic              adapter_err,
  input  wire logic              adapter_bus_err,
  input  wire logic              adapter_user_maint_io,
  input  wire logic              adapter_aio,
  input  wire logic [1:0]        cycle_steal_control_word,
  input  wire logic              channel_control_word_done,
  input  wire logic              adapter_l1_req,
  // maintenance indirect and direct operations
  input  wire logic              maint_indirect_start,
  input  wire logic              maint_direct_start,
  input  wire logic              maint_busy,
  // reactions
  output logic                   alu_par_out,
  output logic                   alu_compare_force,
  output logic                   prog_halt,
  output logic                   aio_halt,
  output logic                   hard_stop,
  output logic                   indirect_allowed,
  output logic                   direct_allowed,
  output logic                   high_level_interrupt_request,
  output logic                   level1_irq,
  output logic                   adapter_halt,
  output logic                   mask_channel_req,
  output logic                   adapter_bus_par_check,
  output logic                   op_error
);

  // ==========================================================
  // decode helpers
  function automatic logic out_to(input logic [7:0] reg_no);
    out_to = instr_valid && instr_is_io && instr_is_output && (instr_ext_reg == reg_no);
  endfunction

  function automatic logic apb_wr(input logic [ADDR_W-1:0] a);
    apb_wr = psel && penable && pwrite && (paddr == a);
  endfunction

  // ==========================================================
  // mode controls
  logic              prog_bypass_q;
  logic              maint_bypass_q;
  logic              maint_bus_stop_q;
  logic              l1_adapter_mask_q;
  logic              force_q;
  logic              bypass_mode;
  logic              maint_clear;
  logic [7:0]        byte1;

  assign byte1       = instr_data[7:0];
  assign maint_clear = apb_wr(ADDR_MAINT_CTL) && pwdata[MC_CLEAR];
  assign bypass_mode = (maint_bypass_q || prog_bypass_q)
                       && !(maint_bus_stop_q && !maint_bypass_q);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prog_bypass_q <= 1'b0;
    end else if (out_to(XR_BYPASS_CTL) && byte1[BYP_SET_BIT]) begin
      prog_bypass_q <= 1'b1;
    end else if (out_to(XR_BYPASS_CTL) && byte1[BYP_CLR_BIT]) begin
      prog_bypass_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      maint_bypass_q   <= 1'b0;
      maint_bus_stop_q <= 1'b0;
    end else if (apb_wr(ADDR_MAINT_CTL)) begin
      maint_bypass_q   <= pwdata[MC_BYPASS];
      maint_bus_stop_q <= pwdata[MC_BUS_STOP];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      l1_adapter_mask_q <= 1'b0;
    end else if (out_to(XR_SET_MASK) && byte1[L1_MASK_BIT]) begin
      l1_adapter_mask_q <= 1'b1;
    end else if (out_to(XR_RESET_MASK) && byte1[L1_MASK_BIT]) begin
      l1_adapter_mask_q <= 1'b0;
    end
  end

  // one-cycle forced check per output 78
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      force_q <= 1'b0;
    end else begin
      force_q <= out_to(XR_FORCE_CHECK);
    end
  end

  assign alu_compare_force = force_q;
  // inverted parity exercises the downstream checkers
  assign alu_par_out       = alu_par_in ^ force_q;

  // ==========================================================
  // hard error detection
  logic [HL_WIDTH-1:0] hard_det;
  logic                in_7x;
  logic                prog_err_any;
  logic [PE_WIDTH-1:0] prog_det;
  logic                maint_aio;
  logic                bus_err_hard;

  assign in_7x     = instr_valid && instr_is_io && !instr_is_output
                     && (instr_ext_reg[7:4] == XR_7X_GROUP);
  assign maint_aio = adapter_aio && cycle_steal_control_word[MAINT_AIO_BIT];
  assign bus_err_hard = maint_bus_stop_q && adapter_bus_err;

  assign prog_det[PE_LVL5_IO] = instr_valid && instr_is_io && (prog_level == 3'd5);
  assign prog_det[PE_INV_OP]  = instr_valid && (!instr_opcode_valid
                                || (instr_is_io && !ext_reg_valid));
  assign prog_det[PE_ADP_PGM] = 1'b0;
  assign prog_err_any = |prog_det;

  always_comb begin
    hard_det = '0;
    hard_det[HL_LS_PAR]   = ls_read && (ls_byte_par_err[0] || ls_byte_par_err[1]);
    hard_det[HL_Z_PAR]    = (|z_byte_par_err) && !in_7x;
    hard_det[HL_AB_PAR]   = alu_op && ((a_bus_par_err && !a_bus_degate)
                            || (b_bus_par_err && !b_bus_degate));
    hard_det[HL_ALU_CMP]  = (alu_result_a != alu_result_b) || force_q;
    hard_det[HL_IOD_PAR]  = io_dreg_load && io_dreg_par_err && !io_dreg_from_bus;
    hard_det[HL_PRE_PAR]  = prefetch_xfer && prefetch_par_err;
    hard_det[HL_SAR_PAR]  = storage_addr_reg_par_err;
    hard_det[HL_L1_PROG]  = prog_err_any && (prog_level == 3'd1);
    hard_det[HL_BUS_STOP] = bus_err_hard;
    hard_det[HL_CTL_PAR]  = control_store_par_err;
  end

  assign adapter_bus_par_check = io_dreg_load && io_dreg_from_bus && io_dreg_par_err;

  // ==========================================================
  // hard latches and stop state
  logic [HL_WIDTH-1:0] hard_latch_q;
  logic                forced_q;
  logic                l1_queued_q;
  cueh_state_t         state_q;
  logic                hard_check;

  assign hard_check = |hard_det;

  // latches survive until maintenance clear; set wins over clear
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hard_latch_q <= '0;
    end else begin
      hard_latch_q <= (maint_clear ? '0 : hard_latch_q) | hard_det;
    end
  end

  // remembers whether the latched error came from the forced path
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      forced_q <= 1'b0;
    end else if (hard_check) begin
      forced_q <= force_q && (hard_det == (HL_WIDTH'(1) << HL_ALU_CMP));
    end else if (maint_clear) begin
      forced_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= CUEH_RUN;
    end else begin
      unique case (state_q)
        CUEH_RUN: begin
          if (hard_check && !bypass_mode) begin
            state_q <= CUEH_STOPPED;
          end
        end
        CUEH_STOPPED: begin
          // a fresh hard check outside bypass mode in the clearing cycle keeps the unit stopped
          if (maint_clear && !(hard_check && !bypass_mode)) begin
            state_q <= CUEH_RUN;
          end
        end
        default: state_q <= CUEH_RUN;
      endcase
    end
  end

  // queued level 1 for hard checks; released only in bypass
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      l1_queued_q <= 1'b0;
    end else if (hard_check) begin
      l1_queued_q <= 1'b1;
    end else if (maint_clear || (l1_queued_q && bypass_mode)) begin
      l1_queued_q <= 1'b0;
    end
  end

  logic stopped;
  assign stopped          = (state_q == CUEH_STOPPED);
  assign prog_halt        = stopped;
  assign aio_halt         = stopped;
  assign hard_stop        = stopped;
  assign mask_channel_req = stopped;
  assign direct_allowed   = 1'b1;
  assign indirect_allowed = !stopped || bypass_mode;

  // ==========================================================
  // non-hard reactions, routed to the originating user
  logic adp_prog_err;
  logic adp_maint_err;
  logic adp_maint_aio_err;

  assign adp_prog_err      = adapter_err && !bus_err_hard && !adapter_user_maint_io && !maint_aio;
  assign adp_maint_err     = adapter_err && !bus_err_hard && adapter_user_maint_io;
  assign adp_maint_aio_err = adapter_err && !bus_err_hard && maint_aio;

  // registered reactions
  logic high_level_interrupt_request_q;
  logic l1_q;
  logic halt_q;
  logic op_err_q;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      high_level_interrupt_request_q <= 1'b0;
    end else begin
      high_level_interrupt_request_q <= (hard_check && !bypass_mode)
                || adp_maint_err
                || (adp_maint_aio_err && channel_control_word_done)
                || (maint_indirect_start && maint_busy);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      l1_q <= 1'b0;
    end else begin
      l1_q <= (prog_err_any && (prog_level != 3'd1))
              || adp_prog_err
              || (adapter_l1_req && !l1_adapter_mask_q && !adp_maint_err)
              || (l1_queued_q && bypass_mode);
    end
  end

  // non-hard errors never touch the stop state
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      halt_q <= 1'b0;
    end else begin
      halt_q <= adapter_err || bus_err_hard
                || (stopped && adapter_aio);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      op_err_q <= 1'b0;
    end else if (maint_indirect_start && maint_busy) begin
      op_err_q <= 1'b1;
    end else if (maint_clear) begin
      op_err_q <= 1'b0;
    end
  end

  assign high_level_interrupt_request = high_level_interrupt_request_q;
  assign level1_irq                   = l1_q;
  assign adapter_halt                 = halt_q;
  assign op_error                     = op_err_q;

  // ==========================================================
  // program-visible error record
  logic [PE_WIDTH-1:0] prog_err_q;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prog_err_q <= '0;
    end else begin
      prog_err_q <= (maint_clear ? '0 : prog_err_q) | prog_det
                    | {adp_prog_err, 2'b00};
    end
  end

  // ==========================================================
  // apb slave, zero wait states
  logic [31:0] rdata_d;

  always_comb begin
    rdata_d = RESET_WORD;
    unique case (paddr)
      ADDR_MAINT_CTL:  rdata_d = {28'h0, forced_q, 1'b0, maint_bus_stop_q, maint_bypass_q};
      ADDR_STATUS:     rdata_d = {25'h0, op_err_q, l1_adapter_mask_q, l1_queued_q,
                                  prog_bypass_q, bypass_mode, stopped, 1'b0};
      ADDR_HARD_LATCH: rdata_d = {22'h0, hard_latch_q};
      ADDR_PROG_ERR:   rdata_d = {29'h0, prog_err_q};
      default:         rdata_d = RESET_WORD;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !(paddr == ADDR_MAINT_CTL || paddr == ADDR_STATUS
                   || paddr == ADDR_HARD_LATCH || paddr == ADDR_PROG_ERR);

  // program-side readout of genuine latches is not offered; apb is maintenance only
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= RESET_WORD;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_d;
    end
  end

endmodule // cueh_error_handler

//--- cueh_checker.sv
// checker: timing relations between the error handler's causes and reactions
// assumes one clock domain; bound onto every handler instance below
`timescale 1ns/1ps
module cueh_checker
  import cueh_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic storage_addr_reg_par_err,
  input wire logic alu_par_in,
  input wire logic alu_par_out,
  input wire logic alu_compare_force,
  input wire logic io_dreg_load,
  input wire logic io_dreg_from_bus,
  input wire logic io_dreg_par_err,
  input wire logic adapter_err,
  input wire logic adapter_user_maint_io,
  input wire logic maint_indirect_start,
  input wire logic maint_busy,
  input wire logic prog_halt,
  input wire logic aio_halt,
  input wire logic hard_stop,
  input wire logic mask_channel_req,
  input wire logic indirect_allowed,
  input wire logic direct_allowed,
  input wire logic high_level_interrupt_request,
  input wire logic level1_irq,
  input wire logic adapter_bus_par_check,
  input wire logic op_error
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // ==========
  // reactions
  a_force_parity: assert property (alu_compare_force |-> alu_par_out != alu_par_in)
    else $error("forced check without bad alu parity");
  a_stop_halts: assert property (hard_stop |-> prog_halt && aio_halt && mask_channel_req)
    else $error("stopped unit still runs program or adapter work");
  a_direct_kept: assert property (direct_allowed)
    else $error("direct maintenance access withdrawn");
  a_indirect_free: assert property (!hard_stop |-> indirect_allowed)
    else $error("indirect access blocked while running");
  // any apb access may be the maintenance clear, so only idle cycles are held
  a_stop_sticky: assert property (hard_stop && !psel |=> hard_stop)
    else $error("hard stop dropped without maintenance clear");
  a_sar_reacts: assert property (storage_addr_reg_par_err |-> ##[1:2] (hard_stop || level1_irq))
    else $error("storage address parity fault ignored");
  a_stop_reports: assert property ($rose(hard_stop) |-> high_level_interrupt_request && !level1_irq)
    else $error("hard stop without maintenance interrupt or with level 1");
  a_bus_check: assert property (io_dreg_load && io_dreg_from_bus && io_dreg_par_err |-> ##[0:1] adapter_bus_par_check)
    else $error("bus-loaded data parity fault not flagged on bus");
  a_maint_no_l1: assert property (adapter_err && adapter_user_maint_io |=> !level1_irq)
    else $error("maintenance io error reached the program");
  a_busy_start: assert property (maint_indirect_start && maint_busy |=> op_error && high_level_interrupt_request)
    else $error("start while busy not flagged");
endmodule // cueh_checker

bind cueh_error_handler cueh_checker #(.ADDR_W(ADDR_W)) i_cueh_checker (.*);

//--- cueh_maint_model.sv
// maintenance subsystem model: starts indirect operations and holds its busy span
// assumes the bench raises start_req for one cycle, right after a clock edge
`timescale 1ns/1ps
module cueh_maint_model (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic start_req,
  input  wire logic ignore_busy,
  output logic      maint_indirect_start,
  output logic      maint_busy
);
  logic [2:0] busy_cnt_q;

  assign maint_busy = busy_cnt_q != 3'h0;

  // ==========
  // indirect operation sequencing
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_cnt_q <= 3'h0;
      maint_indirect_start <= 1'b0;
    end else begin
      // a start during busy only when the bench asks for the fault
      maint_indirect_start <= start_req && (!maint_busy || ignore_busy);
      // busy follows the accepted start, so a clean start never meets busy
      if (maint_indirect_start && !maint_busy) begin
        busy_cnt_q <= 3'h7;
      end else if (maint_busy) begin
        busy_cnt_q <= busy_cnt_q - 3'h1;
      end
    end
  end
endmodule // cueh_maint_model

//--- cueh_error_handler_tb.sv
// self-checking bench for the control unit error handler
// assumes zero-wait apb answers; maintenance model drives the indirect start
`timescale 1ns/1ps
module cueh_error_handler_tb;
  import cueh_pkg::*;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, perr;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, alu_par_out, alu_compare_force, prog_halt, aio_halt, hard_stop;
  logic        indirect_allowed, direct_allowed, high_level_interrupt_request, level1_irq, adapter_halt;
  logic        mask_channel_req, adapter_bus_par_check, op_error, maint_indirect_start, maint_busy;
  logic [63:0] s = 64'h0;
  logic [7:0]  xr = 8'h7d;
  logic [15:0] dat = 16'h0;
  logic [2:0]  lvl = 3'h3;
  logic [5:0]  seen = 6'h0;
  logic [1:0]  pseen = 2'h0;
  int          miscompares = 0, cmp_count = 0, cycles = 0;
  logic [63:0] hs[14] = '{64'h60, 64'ha0, 64'h200, 64'h3000, 64'h5000, 64'h20000, 64'h280000,
                          64'hc00000, 64'h1000000, 64'h2000000, 64'h120, 64'h40, 64'h800000, 64'h21b};
  int          hb[14] = '{0, 0, 1, 2, 2, 3, 4, 5, 6, 9, -1, -1, -1, -1};

  cueh_error_handler i_cueh_error_handler (.*,
    .instr_valid(s[0]), .instr_is_io(s[1]), .instr_is_output(s[2]), .instr_opcode_valid(s[3]),
    .ext_reg_valid(s[4]), .instr_ext_reg(xr), .instr_data(dat), .prog_level(lvl), .ls_read(s[5]),
    .ls_byte_par_err(s[8:6]), .z_byte_par_err(s[11:9]), .alu_op(s[12]), .a_bus_par_err(s[13]),
    .b_bus_par_err(s[14]), .a_bus_degate(s[15]), .b_bus_degate(s[16]), .alu_result_a(8'h00),
    .alu_result_b({7'h0, s[17]}), .alu_par_in(s[18]), .io_dreg_load(s[19]), .io_dreg_from_bus(s[20]),
    .io_dreg_par_err(s[21]), .prefetch_xfer(s[22]), .prefetch_par_err(s[23]),
    .storage_addr_reg_par_err(s[24]), .control_store_par_err(s[25]), .adapter_err(s[26]),
    .adapter_bus_err(s[27]), .adapter_user_maint_io(s[28]), .adapter_aio(s[29]),
    .cycle_steal_control_word(s[31:30]), .channel_control_word_done(s[32]), .adapter_l1_req(s[33]),
    .maint_direct_start(1'b0));
  cueh_maint_model i_cueh_maint_model (.core_clk(core_clk), .reset_n(reset_n), .start_req(s[34]),
    .ignore_busy(s[35]), .maint_indirect_start(maint_indirect_start), .maint_busy(maint_busy));

  // ==========
  // clock, reaction capture, hang guard
  always #2 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    seen <= seen | {adapter_bus_par_check, op_error, adapter_halt, level1_irq, hard_stop,
                    high_level_interrupt_request};
    if (reset_n) pseen <= pseen | {alu_compare_force, alu_par_out};
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end

  // ==========
  // tasks
  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask

  task clr;
    apb(1'b1, ADDR_MAINT_CTL, 32'h4);
  endtask

  // one-cycle stimulus, then reactions gathered over the next cycles
  task go(input logic [63:0] v, input logic [5:0] e, input logic [5:0] m);
    #1 seen = 6'h0;
    @(posedge core_clk) s <= v;
    @(posedge core_clk) s <= 64'h0;
    repeat (3) @(posedge core_clk);
    #1 chk({26'h0, seen & m}, {26'h0, e});
  endtask

  task ins(input logic [7:0] x, input logic [15:0] d, input logic [2:0] l, input logic [63:0] v,
           input logic [5:0] e, input logic [5:0] m);
    @(posedge core_clk);
    xr <= x;
    dat <= d;
    lvl <= l;
    go(v, e, m);
  endtask

  // ==========
  // sequence
  initial begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    apb(1'b1, ADDR_STATUS, 32'hff);
    rd(ADDR_STATUS, 32'h0);
    rd(ADDR_HARD_LATCH, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk({rdat[30:0], perr}, 32'h1);
    for (int i = 0; i < 14; i++) begin
      go(hs[i], hb[i] < 0 ? 6'h00 : 6'h03, 6'h07);
      chk({27'h0, prog_halt, aio_halt, mask_channel_req, indirect_allowed, direct_allowed},
          hb[i] < 0 ? 32'h3 : 32'h1d);
      rd(ADDR_HARD_LATCH, hb[i] < 0 ? 32'h0 : 32'h1 << hb[i]);
      if (i == 0) rd(ADDR_MAINT_CTL, 32'h0);
      if (i == 8) rd(ADDR_STATUS, 32'h12);
      clr();
    end
    go(64'h380000, 6'h20, 6'h23);
    ins(XR_FORCE_CHECK, 16'h0, 3'h3, 64'h1f, 6'h03, 6'h07);
    rd(ADDR_HARD_LATCH, 32'h8);
    chk({30'h0, pseen}, 32'h3);
    clr();
    ins(XR_BYPASS_CTL, 16'h0010, 3'h3, 64'h1f, 6'h00, 6'h3f);
    rd(ADDR_STATUS, 32'h0c);
    go(64'h1000000, 6'h04, 6'h07);
    rd(ADDR_HARD_LATCH, 32'h40);
    clr();
    apb(1'b1, ADDR_MAINT_CTL, 32'h2);
    rd(ADDR_STATUS, 32'h08);
    apb(1'b1, ADDR_MAINT_CTL, 32'h3);
    rd(ADDR_STATUS, 32'h0c);
    ins(XR_BYPASS_CTL, 16'h0020, 3'h3, 64'h1f, 6'h00, 6'h3f);
    rd(ADDR_STATUS, 32'h04);
    apb(1'b1, ADDR_MAINT_CTL, 32'h0);
    rd(ADDR_STATUS, 32'h0);
    ins(XR_SET_MASK, 16'h0002, 3'h3, 64'h1f, 6'h00, 6'h3f);
    rd(ADDR_STATUS, 32'h20);
    go(64'h2_0000_0000, 6'h00, 6'h04);
    ins(XR_RESET_MASK, 16'h0002, 3'h3, 64'h1f, 6'h00, 6'h3f);
    go(64'h2_0000_0000, 6'h04, 6'h04);
    ins(8'h74, 16'h0, 3'h5, 64'h1b, 6'h04, 6'h07);
    rd(ADDR_PROG_ERR, 32'h1);
    ins(8'h74, 16'h0, 3'h3, 64'h11, 6'h04, 6'h07);
    ins(8'h74, 16'h0, 3'h3, 64'h0b, 6'h04, 6'h07);
    rd(ADDR_PROG_ERR, 32'h3);
    ins(8'h74, 16'h0, 3'h1, 64'h11, 6'h03, 6'h07);
    rd(ADDR_HARD_LATCH, 32'h80);
    clr();
    go(64'h2400_0000, 6'h0c, 6'h0f);
    go(64'h0c00_0000, 6'h0c, 6'h0f);
    go(64'h1c00_0000, 6'h09, 6'h0f);
    go(64'h6400_0000, 6'h08, 6'h0f);
    go(64'h1_6400_0000, 6'h09, 6'h0f);
    apb(1'b1, ADDR_MAINT_CTL, 32'h6);
    go(64'h0c00_0000, 6'h03, 6'h07);
    rd(ADDR_HARD_LATCH, 32'h100);
    clr();
    go(64'h4_0000_0000, 6'h00, 6'h11);
    go(64'hc_0000_0000, 6'h11, 6'h11);
    rd(ADDR_STATUS, 32'h40);
    clr();
    rd(ADDR_STATUS, 32'h0);
    final_report();
  end
endmodule // cueh_error_handler_tb
